// >>> rtl/pbs_pkg.sv
// shared constants for the pipelined burst synchronous sram
package pbs_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int BURST_W = 2;
  localparam logic [1:0] BURST_START = 2'h0;
  localparam logic [1:0] BURST_STEP = 2'h1;
  typedef enum logic [1:0] {
    PBS_IDLE = 2'b00,
    PBS_READ = 2'b01,
    PBS_WRITE = 2'b10
  } pbs_state_e;
endpackage

// >>> rtl/pbs_burst_counter.sv
// two-bit burst counter with linear or interleaved order
`timescale 1ns/10ps
module pbs_burst_counter #(
  parameter int BW = pbs_pkg::BURST_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // control
  input wire logic load,
  input wire logic [BW-1:0] startLow,
  input wire logic step,
  input wire logic burstOrderSelect,
  // result
  output logic [BW-1:0] lowAddr
);
  logic [BW-1:0] startLow_r, startLow_nxt;
  logic [BW-1:0] count_r, count_nxt;

  initial begin
    if (BW != 2) $error("burst counter must be two bits");
  end

  always_comb begin
    startLow_nxt = startLow_r;
    count_nxt = count_r;
    if (load) begin
      startLow_nxt = startLow;
      count_nxt = pbs_pkg::BURST_START;
    end else if (step) begin
      count_nxt = count_r + pbs_pkg::BURST_STEP;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      startLow_r <= pbs_pkg::BURST_START;
      count_r <= pbs_pkg::BURST_START;
    end else begin
      startLow_r <= startLow_nxt;
      count_r <= count_nxt;
    end
  end

  // wraps within four addresses in either order
  assign lowAddr = burstOrderSelect ? (startLow_r ^ count_r) : (startLow_r + count_r);
endmodule

// >>> rtl/pbs_sram.sv
// pipelined burst synchronous sram, 64k words of 32 bits
`timescale 1ns/10ps
module pbs_sram #(
  parameter int AW = pbs_pkg::ADDR_W,
  parameter int DW = pbs_pkg::DATA_W,
  parameter int NL = pbs_pkg::LANES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // address and strobes
  input wire logic [AW-1:0] addressInputs,
  input wire logic procAddressStrobe_n,
  input wire logic ctrlAddressStrobe_n,
  input wire logic burstAdvance_n,
  // chip enables
  input wire logic chipEnablePrimary_n,
  input wire logic chipEnableExpandHigh,
  input wire logic chipEnableExpandLow_n,
  // write controls
  input wire logic globalWrite_n,
  input wire logic writeEnable_n,
  input wire logic [NL-1:0] byteWriteLane_n,
  // static and asynchronous controls
  input wire logic outputDriveEnable_n,
  input wire logic sleepRequest,
  input wire logic burstOrderSelect,
  // data lanes
  input wire logic [DW-1:0] dataLaneIn,
  output logic [DW-1:0] dataLaneOut,
  output logic dataLaneOe,
  // status
  output logic lowPower
);
  localparam int LW = DW / NL;
  localparam int BW = pbs_pkg::BURST_W;

  initial begin
    if (LW != pbs_pkg::LANE_W || NL != pbs_pkg::LANES) $error("unsupported lane layout");
    if (AW <= BW) $error("address too narrow for burst");
  end

  // =====================================
  // storage
  logic [DW-1:0] memArray [0:(1<<AW)-1];

  // =====================================
  // strobe decode
  logic enabled, procStart, ctrlStart, startCycle, deselectCycle, writeReq, activeCycle;
  logic [NL-1:0] laneMask;
  pbs_pkg::pbs_state_e state_r, state_nxt;
  logic [BW-1:0] startLowCopy_r, startLowCopy_nxt, wrLow, stepCount;
  logic [AW-BW-1:0] baseAddr_r, baseAddr_nxt;
  logic sleep_r, sleep_nxt;
  logic [DW-1:0] readData_r, readData_nxt;
  logic readValid_r, readValid_nxt;
  logic [BW-1:0] lowAddr;
  logic [AW-1:0] curAddr;
  logic advance;

  assign enabled = !chipEnablePrimary_n && chipEnableExpandHigh && !chipEnableExpandLow_n;
  // processor strobe ignored while primary enable is high
  assign procStart = !procAddressStrobe_n && !chipEnablePrimary_n;
  // processor strobe has priority over controller strobe
  // with primary enable high the controller strobe still acts, as a deselect
  assign ctrlStart = (procAddressStrobe_n || chipEnablePrimary_n) && !ctrlAddressStrobe_n;
  assign startCycle = (procStart || ctrlStart) && enabled;
  assign deselectCycle = (procStart || ctrlStart) && !enabled;
  assign writeReq = !globalWrite_n || (!writeEnable_n && (byteWriteLane_n != {NL{1'b1}}));
  assign advance = !burstAdvance_n && (state_r != pbs_pkg::PBS_IDLE) && !procStart && !ctrlStart;

  // lane selection: global write overrides lanes
  always_comb begin
    laneMask = '0;
    if (!globalWrite_n) begin
      laneMask = {NL{1'b1}};
    end else if (!writeEnable_n) begin
      laneMask = ~byteWriteLane_n;
    end
  end

  // =====================================
  // burst counter
  pbs_burst_counter #(
    .BW(BW)
  ) u_counter (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .load(startCycle && !sleepRequest),
    .startLow(addressInputs[BW-1:0]),
    .step(advance && !sleepRequest),
    .burstOrderSelect(burstOrderSelect),
    .lowAddr(lowAddr)
  );

  assign curAddr = {baseAddr_r, lowAddr};
  // a continuing write with advance lands on the next burst address
  assign stepCount = burstOrderSelect ? (lowAddr ^ startLowCopy_r) : BW'(lowAddr - startLowCopy_r);
  assign wrLow = !advance ? lowAddr :
                 burstOrderSelect ? (startLowCopy_r ^ BW'(stepCount + BW'(1))) : BW'(lowAddr + BW'(1));

  // =====================================
  // cycle state
  always_comb begin
    state_nxt = state_r;
    baseAddr_nxt = baseAddr_r;
    sleep_nxt = sleep_r;
    startLowCopy_nxt = startLowCopy_r;
    if (sleepRequest) begin
      sleep_nxt = 1'b1;
    end else if (startCycle) begin
      baseAddr_nxt = addressInputs[AW-1:BW];
      startLowCopy_nxt = addressInputs[BW-1:0];
      sleep_nxt = 1'b0;
      // processor strobe cannot start a write
      if (ctrlStart && writeReq) begin
        state_nxt = pbs_pkg::PBS_WRITE;
      end else begin
        state_nxt = pbs_pkg::PBS_READ;
      end
    end else if (deselectCycle) begin
      state_nxt = pbs_pkg::PBS_IDLE;
    end else if (state_r != pbs_pkg::PBS_IDLE) begin
      // continuing cycles follow the write controls
      state_nxt = writeReq ? pbs_pkg::PBS_WRITE : pbs_pkg::PBS_READ;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_r <= pbs_pkg::PBS_IDLE;
      baseAddr_r <= '0;
      sleep_r <= 1'b0;
      startLowCopy_r <= '0;
    end else begin
      startLowCopy_r <= startLowCopy_nxt;
      state_r <= state_nxt;
      baseAddr_r <= baseAddr_nxt;
      sleep_r <= sleep_nxt;
    end
  end

  assign activeCycle = !sleepRequest && (state_r != pbs_pkg::PBS_IDLE);

  // =====================================
  // array write, self timed on the sampling edge
  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : g_lane
      always_ff @(posedge sys_clk) begin
        if (!sleepRequest && !deselectCycle && (startCycle ? ctrlStart : (state_r != pbs_pkg::PBS_IDLE)) &&
            laneMask[g]) begin
          memArray[startCycle ? addressInputs : {baseAddr_r, wrLow}][g*LW +: LW] <= dataLaneIn[g*LW +: LW];
        end
      end
    end
  endgenerate

  // =====================================
  // read pipeline
  always_comb begin
    readData_nxt = readData_r;
    readValid_nxt = 1'b0;
    if (activeCycle && state_r == pbs_pkg::PBS_READ) begin
      readData_nxt = memArray[curAddr];
      readValid_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      readData_r <= '0;
      readValid_r <= 1'b0;
    end else begin
      readData_r <= readData_nxt;
      readValid_r <= readValid_nxt;
    end
  end

  assign dataLaneOut = readData_r;
  // output enable gates drive without a clock
  assign dataLaneOe = readValid_r && !outputDriveEnable_n && !sleepRequest;
  assign lowPower = sleep_r || sleepRequest;
endmodule

// >>> tb/pbs_sram_sva.sv
// port assertions for the burst sram
`timescale 1ns/10ps
module pbs_sram_sva (
  // clock, reset and controls
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic procAddressStrobe_n,
  input wire logic ctrlAddressStrobe_n,
  input wire logic chipEnablePrimary_n,
  input wire logic globalWrite_n,
  input wire logic outputDriveEnable_n,
  input wire logic sleepRequest,
  // data side
  input wire logic [pbs_pkg::DATA_W-1:0] dataLaneOut,
  input wire logic dataLaneOe,
  input wire logic lowPower
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire logic wrStart = !ctrlAddressStrobe_n && procAddressStrobe_n && !globalWrite_n;
  wire logic noStart = procAddressStrobe_n && ctrlAddressStrobe_n;
  AST_OE_GATED: assert property (dataLaneOe |-> !outputDriveEnable_n) else $error("oe gate");
  AST_SLEEP_QUIET: assert property (sleepRequest |-> !dataLaneOe) else $error("sleep drive");
  AST_SLEEP_HOLD: assert property (sleepRequest ##1 sleepRequest |-> $stable(dataLaneOut)) else $error("sleep");
  AST_LP_ENTER: assert property ($fell(sleepRequest) |-> lowPower) else $error("low power");
  AST_LP_HOLD: assert property (lowPower && !sleepRequest && noStart |=> lowPower) else $error("lp hold");
  AST_WR_NO_DRIVE: assert property (wrStart |-> ##2 !dataLaneOe) else $error("write drive");
  AST_WR_KEEP: assert property (wrStart |-> ##2 $stable(dataLaneOut)) else $error("write data");
  AST_DESELECT: assert property (!ctrlAddressStrobe_n && chipEnablePrimary_n |-> ##2 !dataLaneOe) else $error("desel");
endmodule

// >>> tb/pbs_host.sv
// cache controller model driving the burst sram
`timescale 1ns/10ps
module pbs_host (
  // clock
  input wire logic sys_clk,
  // ctl = proc, ctrl, advance, primary, global write, write enable; all low active
  output logic [5:0] ctl = 6'h3b,
  output logic [3:0] lane_n = 4'hf,
  output logic [15:0] addr = 16'h0000,
  output logic [31:0] wrData = 32'h0000_0000,
  output logic outEn_n = 1'b0
);
  // one bus cycle, launched just after the edge
  task automatic cyc(input logic [5:0] c, input logic [3:0] l, input logic [15:0] a = 16'h0000,
                     input logic [31:0] d = 32'h0000_0000);
    logic wr;
    @(posedge sys_clk);
    wr = !c[1] || !c[0];
    ctl <= c;
    lane_n <= l;
    addr <= a;
    wrData <= wr ? d : ~wrData;
    outEn_n <= wr;
  endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the burst sram
`timescale 1ns/10ps
module tb_top;
  localparam logic [5:0] IDLE = 6'h3b;
  logic sys_clk;
  logic rstn = 1'b0;
  logic order = 1'b0;
  logic sleep = 1'b0;
  logic [5:0] ctl;
  logic [3:0] lane_n;
  logic [15:0] addr;
  logic [31:0] wrData, dataLaneOut;
  logic outEn_n, dataLaneOe, lowPower;
  logic [31:0] m [4];
  int fail_count = 0;
  int samples_checked = 0;
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  pbs_host u_host (.sys_clk(sys_clk), .ctl(ctl), .lane_n(lane_n), .addr(addr), .wrData(wrData), .outEn_n(outEn_n));
  pbs_sram u_dut (.sys_clk(sys_clk), .rstn(rstn), .addressInputs(addr), .procAddressStrobe_n(ctl[5]),
    .ctrlAddressStrobe_n(ctl[4]), .burstAdvance_n(ctl[3]), .chipEnablePrimary_n(ctl[2]), .chipEnableExpandHigh(1'b1),
    .chipEnableExpandLow_n(1'b0), .globalWrite_n(ctl[1]), .writeEnable_n(ctl[0]), .byteWriteLane_n(lane_n),
    .outputDriveEnable_n(outEn_n), .sleepRequest(sleep), .burstOrderSelect(order), .dataLaneIn(wrData),
    .dataLaneOut(dataLaneOut), .dataLaneOe(dataLaneOe), .lowPower(lowPower));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // global writes ignore lane enables; then a two-lane write and a deselect
  task automatic write_burst;
    for (int k = 0; k < 4; k++) begin
      m[2'(1 + k)] = {8'(k + 1), 24'h3c_5a96};
      u_host.cyc(k == 0 ? 6'h29 : 6'h31, 4'h5, 16'h0011, m[2'(1 + k)]);
    end
    u_host.cyc(6'h2a, 4'ha, 16'h0012, 32'h7788_99aa);
    m[2] = {m[2][31:24], 8'h88, m[2][15:8], 8'haa};
    u_host.cyc(6'h0f, 4'hf, 16'h0013);
  endtask
  task automatic read_burst(input logic o, input logic [1:0] s);
    order <= o;
    u_host.cyc(6'h1b, 4'hf, {14'h0004, s});
    for (int i = 0; i < 5; i++) begin
      u_host.cyc(i < 3 ? 6'h33 : IDLE, 4'hf);
      #1;
      if (i == 1) chk("drive", {31'h0, dataLaneOe}, 32'h0000_0001);
      if (i > 0) chk("word", dataLaneOut, m[o ? s ^ 2'(i - 1) : s + 2'(i - 1)]);
    end
  endtask
  // advance pulses while asleep; low power outlasts the request
  task automatic sleep_check;
    @(posedge sys_clk) sleep <= 1'b1;
    repeat (2) u_host.cyc(6'h33, 4'hf);
    sleep <= 1'b0;
    u_host.cyc(IDLE, 4'hf);
    #1;
    chk("low power", {31'h0, lowPower}, 32'h0000_0001);
    u_host.cyc(6'h1b, 4'hf, 16'h0010);
    u_host.cyc(IDLE, 4'hf);
    #1;
    chk("wake", {31'h0, lowPower}, 32'h0000_0000);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    write_burst;
    read_burst(1'b0, 2'h1);
    read_burst(1'b1, 2'h1);
    sleep_check;
    read_burst(1'b1, 2'h2);
    stop_test;
  end
endmodule
bind pbs_sram pbs_sram_sva u_sva (.sys_clk(sys_clk), .rstn(rstn), .procAddressStrobe_n(procAddressStrobe_n),
  .ctrlAddressStrobe_n(ctrlAddressStrobe_n), .chipEnablePrimary_n(chipEnablePrimary_n), .globalWrite_n(globalWrite_n),
  .outputDriveEnable_n(outputDriveEnable_n), .sleepRequest(sleepRequest), .dataLaneOut(dataLaneOut),
  .dataLaneOe(dataLaneOe), .lowPower(lowPower));
